// [verilog/dect_pkg.sv]
// Shared constants and types for the dual event counter timer
package dect_pkg;

  localparam int CLK_FREQ_HZ     = 50_000_000;
  localparam int TICK_PERIOD_US  = 1;
  localparam int TICK_CYCLES     = CLK_FREQ_HZ / 1_000_000 * TICK_PERIOD_US;
  localparam int TICK_CNT_W      = 6;
  localparam int NUM_INST        = 2;
  localparam int SRC_NUM         = 19;
  localparam int CNT_W_DEFAULT   = 32;

  typedef enum logic [4:0] {
    src_off,
    src_microsecond_pulse,
    src_io_a0,
    src_io_a1,
    src_io_a2,
    src_io_a3,
    src_sw_output0,
    src_sw_output1,
    src_sw_output2,
    src_sw_output3,
    src_inst0_begin_evt,
    src_inst1_begin_evt,
    src_inst0_finish_evt,
    src_inst1_finish_evt,
    src_lut_cell0_out,
    src_lut_cell1_out,
    src_exp_begin,
    src_exp_finish,
    src_awaiting_frame_trig
  } dect_src_e;

  typedef enum logic [2:0] {
    qual_low,
    qual_high,
    qual_fall,
    qual_rise,
    qual_both_edges
  } dect_qual_e;

  typedef enum logic [2:0] {
    state_idle,
    state_wait_trig,
    state_running,
    state_done,
    state_wrapped
  } dect_state_e;

  typedef struct packed {
    dect_src_e  cnt_sel;
    dect_qual_e cnt_qual;
    dect_src_e  trig_sel;
    dect_qual_e trig_qual;
    dect_src_e  clr_sel;
    dect_qual_e clr_qual;
  } dect_cfg_s;

  localparam dect_cfg_s CFG_RESET = '{
    cnt_sel:   src_off,
    cnt_qual:  qual_rise,
    trig_sel:  src_off,
    trig_qual: qual_rise,
    clr_sel:   src_off,
    clr_qual:  qual_rise
  };

endpackage

// [verilog/dect_core_if.sv]
// Link between the top and one counter instance
`timescale 1ns/10ps
interface dect_core_if #(parameter int W = 32);
  logic         arm;
  logic         has_trig;
  logic         count_evt;
  logic         trig_evt;
  logic         clear_evt;
  logic [W-1:0] start_delay;
  logic [W-1:0] end_duration;
  logic [W-1:0] count;
  logic [W-1:0] captured;
  logic [2:0]   state;
  logic         begin_evt;
  logic         finish_evt;

  modport top  (output arm, has_trig, count_evt, trig_evt, clear_evt, start_delay, end_duration,
                input count, captured, state, begin_evt, finish_evt);
  modport core (input arm, has_trig, count_evt, trig_evt, clear_evt, start_delay, end_duration,
                output count, captured, state, begin_evt, finish_evt);
endinterface

// [verilog/dect_core.sv]
// One counter instance: state machine, count, capture and events
`timescale 1ns/10ps
module dect_core
  import dect_pkg::*;
#(
  parameter int W = 32
)(
  input  wire logic clk_i,   // Core clock
  input  wire logic rst_n_i, // Synchronised reset, active low
  dect_core_if.core bus      // Config and events from top
);
  import dect_pkg::*;

  dect_state_e  state;
  dect_state_e  next_state;
  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic [W-1:0] captured;
  logic [W-1:0] next_captured;
  logic         begin_evt;
  logic         next_begin;
  logic         finish_evt;
  logic         next_finish;
  logic [W-1:0] count_inc;

  assign count_inc = count + 1'b1;

  always_comb
  begin
    next_state    = state;
    next_count    = count;
    next_captured = captured;
    next_begin    = 1'b0;
    next_finish   = 1'b0;
    if (bus.arm)
    begin
      next_count = '0;
      if (bus.has_trig)
      begin
        next_state = state_wait_trig;
      end
      else
      begin
        next_state = state_running;
        next_begin = (bus.start_delay == '0);                  // [RL5]
      end
    end
    else if (bus.clear_evt && state != state_idle)
    begin
      next_captured = count;                                   // [RL13]
      next_count    = '0;                                      // [RL10]
      next_state    = state_running;
      next_begin    = (bus.start_delay == '0);
    end
    else
    begin
      case (state)
        state_idle:
        begin
          next_state = state_idle;
        end
        state_wait_trig, state_done, state_wrapped:
        begin
          if (bus.has_trig && bus.trig_evt)
          begin
            next_count = '0;                                   // [RL8]
            next_state = state_running;
            next_begin = (bus.start_delay == '0);
          end
        end
        state_running:
        begin
          if (bus.count_evt)
          begin
            if (count == '1)
            begin
              next_count = '0;
              next_state = state_wrapped;                      // [RL16]
            end
            else
            begin
              next_count = count_inc;                          // [RL2]
              next_begin = (count_inc == bus.start_delay);     // [RL5]
              if (count_inc == bus.end_duration)
              begin
                next_finish = 1'b1;                            // [RL6]
                next_state  = state_done;
              end
            end
          end
        end
        default:
        begin
          next_state = state_idle;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state      <= state_idle;
      count      <= '0;
      captured   <= '0;
      begin_evt  <= 1'b0;
      finish_evt <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      count      <= next_count;
      captured   <= next_captured;
      begin_evt  <= next_begin;
      finish_evt <= next_finish;
    end
  end

  assign bus.count      = count;
  assign bus.captured   = captured;
  assign bus.state      = state;
  assign bus.begin_evt  = begin_evt;
  assign bus.finish_evt = finish_evt;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_finish_done: assert property (finish_evt |-> state == state_done && count == bus.end_duration) // [RL6]
    else $error("finish event without done state");
  a_capture_val: assert property (bus.clear_evt && !bus.arm && state != state_idle
    |=> captured == $past(count) && count == '0) // [RL13]
    else $error("count not captured on clear");
  a_trig_start: assert property (state == state_wait_trig && bus.trig_evt && !bus.arm
    |=> state == state_running && count == '0) // [RL8]
    else $error("trigger did not start counting");
  a_count_step: assert property (state == state_running && bus.count_evt && !bus.arm
    && !bus.clear_evt && count != '1 |=> count == $past(count) + 1'b1) // [RL2]
    else $error("count did not advance");
  a_begin_delay: assert property (state == state_running && !bus.arm && !bus.clear_evt
    && bus.count_evt && count_inc == bus.start_delay && count != '1 |=> begin_evt ##1 !begin_evt) // [RL5]
    else $error("start event missing at delay");
  a_wrap_state: assert property (state == state_running && bus.count_evt && count == '1
    && !bus.arm && !bus.clear_evt |=> state == state_wrapped && count == '0) // [RL16]
    else $error("overflow not reported");

  c_done:    cover property (state == state_running ##[1:1000] state == state_done);
  c_wrapped: cover property (state == state_wrapped);
  c_capture: cover property (bus.clear_evt && state == state_running && count != '0);
endmodule

// [verilog/dect_top.sv]
// Top of the dual event counter timer: config store, source select, readback
`timescale 1ns/10ps
// Behaviour
// RL1 - Two counters, chosen by instance select
// RL2 - Count advances on each qualified count event
// RL3 - Nineteen selectable sources for every selector
// RL4 - Count event qualified by level or edge; pulse sources are counted as they come, with no qualification
// RL5 - Begin event after delay counts elapsed
// RL6 - Finish event after duration counts elapsed
// RL7 - Trigger and clear sources mutually exclusive
// RL8 - Qualified trigger starts the counting
// RL9 - Trigger qualified by level or edge; pulse sources trigger as they come, with no qualification
// RL10 - Qualified clear source resets the counter
// RL11 - Clear qualified by level or edge; pulse sources clear as they come, with no qualification
// RL12 - Live count of selected counter readable
// RL13 - Count before reset is captured, readable
// RL14 - State of selected counter readable
// RL15 - All settings kept separately per counter
// RL16 - State is idle, waiting, running, done, wrapped
// RL17 - Off source never gives any occurrence
// RL18 - Microsecond pulse one cycle per microsecond
module dect_top
  import dect_pkg::*;
#(
  parameter int W = CNT_W_DEFAULT
)(
  input  wire logic                 core_clk_i,            // Core clock 50 MHz
  input  wire logic                 rstn_i,                // Async reset, active low
  input  wire logic [3:0]           io_a_i,                // Line inputs
  input  wire logic [3:0]           sw_output_i,           // User outputs
  input  wire logic [1:0]           lut_cell_out_i,        // Logic block outputs
  input  wire logic                 exp_begin_i,           // Exposure start pulse
  input  wire logic                 exp_finish_i,          // Exposure end pulse
  input  wire logic                 awaiting_frame_trig_i, // Frame trigger wait level
  input  wire logic                 instance_select_i,     // Counter 0 or 1
  input  wire logic                 cfg_write_i,           // Write strobe for settings
  input  wire dect_pkg::dect_src_e  count_source_sel_i,    // Count event source
  input  wire dect_pkg::dect_qual_e count_source_qual_i,   // Count event qualification
  input  wire dect_pkg::dect_src_e  start_trig_sel_i,      // Trigger source
  input  wire dect_pkg::dect_qual_e start_trig_qual_i,     // Trigger qualification
  input  wire dect_pkg::dect_src_e  clear_src_sel_i,       // Clear source
  input  wire dect_pkg::dect_qual_e clear_src_qual_i,      // Clear qualification
  input  wire logic [W-1:0]         start_delay_counts_i,  // Counts to begin event
  input  wire logic [W-1:0]         end_duration_counts_i, // Counts to finish event
  output dect_pkg::dect_cfg_s       cfg_readback_o,        // Stored settings, selected
  output logic [W-1:0]              start_delay_o,         // Stored delay, selected
  output logic [W-1:0]              end_duration_o,        // Stored duration, selected
  output logic [W-1:0]              live_count_o,          // Live count, selected
  output logic [W-1:0]              captured_count_o,      // Count at last clear
  output dect_pkg::dect_state_e     instance_state_o,      // State, selected
  output logic                      microsecond_pulse_o,   // One-cycle tick
  output logic [1:0]                inst_begin_evt_o,      // Begin event per counter
  output logic [1:0]                inst_finish_evt_o      // Finish event per counter
);
  import dect_pkg::*;

  localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(TICK_CYCLES - 1);

  logic rst_meta;
  logic rst_n;

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Microsecond tick
  logic [TICK_CNT_W-1:0] tick_cnt;
  logic [TICK_CNT_W-1:0] next_tick_cnt;
  logic                  tick;
  logic                  next_tick;

  always_comb
  begin
    next_tick     = (tick_cnt == TICK_LAST);                   // [RL18]
    next_tick_cnt = next_tick ? '0 : tick_cnt + 1'b1;
  end

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end
    else
    begin
      tick_cnt <= next_tick_cnt;
      tick     <= next_tick;
    end
  end

  assign microsecond_pulse_o = tick;

  // Per-counter settings
  dect_cfg_s    cfg_q      [NUM_INST];
  dect_cfg_s    next_cfg   [NUM_INST];
  logic [W-1:0] delay_q    [NUM_INST];
  logic [W-1:0] next_delay [NUM_INST];
  logic [W-1:0] dur_q      [NUM_INST];
  logic [W-1:0] next_dur   [NUM_INST];
  logic [NUM_INST-1:0] arm;
  logic [NUM_INST-1:0] next_arm;
  dect_cfg_s    wr_cfg;

  always_comb
  begin
    wr_cfg = '{cnt_sel: count_source_sel_i, cnt_qual: count_source_qual_i,
               trig_sel: start_trig_sel_i, trig_qual: start_trig_qual_i,
               clr_sel: clear_src_sel_i, clr_qual: clear_src_qual_i};
    if (start_trig_sel_i != src_off)
    begin
      wr_cfg.clr_sel = src_off;                                // [RL7]
    end
    for (int i = 0; i < NUM_INST; i++)
    begin
      next_cfg[i]   = cfg_q[i];
      next_delay[i] = delay_q[i];
      next_dur[i]   = dur_q[i];
      next_arm[i]   = 1'b0;
      if (cfg_write_i && (instance_select_i == i[0]))          // [RL1] [RL15]
      begin
        next_cfg[i]   = wr_cfg;
        next_delay[i] = start_delay_counts_i;
        next_dur[i]   = end_duration_counts_i;
        next_arm[i]   = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NUM_INST; i++)
      begin
        cfg_q[i]   <= CFG_RESET;
        delay_q[i] <= '0;
        dur_q[i]   <= '0;
      end
      arm <= '0;
    end
    else
    begin
      cfg_q   <= next_cfg;
      delay_q <= next_delay;
      dur_q   <= next_dur;
      arm     <= next_arm;
    end
  end

  // Source vector, one bit per selector value
  logic [SRC_NUM-1:0] src_vec;
  logic [SRC_NUM-1:0] src_prev;
  logic [SRC_NUM-1:0] src_pulse_type;
  logic [1:0]         begin_evt;
  logic [1:0]         finish_evt;

  assign src_vec = {awaiting_frame_trig_i, exp_finish_i, exp_begin_i, lut_cell_out_i,
                    finish_evt, begin_evt, sw_output_i, io_a_i, tick, 1'b0}; // [RL3] [RL17]
  // Pulse sources are taken as they come, without qualification
  assign src_pulse_type = 19'h33c02;

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      src_prev <= '0;
    end
    else
    begin
      src_prev <= src_vec;
    end
  end

  function automatic logic qualify(input dect_src_e sel, input dect_qual_e q,
                                   input logic [SRC_NUM-1:0] cur,
                                   input logic [SRC_NUM-1:0] prv,
                                   input logic [SRC_NUM-1:0] pls);
    logic c;
    logic p;
    logic r;
    c = cur[sel];
    p = prv[sel];
    r = 1'b0;
    if (sel == src_off)
    begin
      r = 1'b0;
    end
    else if (pls[sel])
    begin
      r = c;
    end
    else
    begin
      case (q)
        qual_low:        r = !c;
        qual_high:       r = c;
        qual_fall:       r = p && !c;
        qual_rise:       r = !p && c;
        qual_both_edges: r = p ^ c;
        default:         r = 1'b0;
      endcase
    end
    return r;
  endfunction

  logic [W-1:0]  cnt_rd [NUM_INST];
  logic [W-1:0]  cap_rd [NUM_INST];
  dect_state_e   st_rd  [NUM_INST];
  logic [1:0]    cnt_evt_dbg;

  for (genvar g = 0; g < NUM_INST; g++)
  begin : g_inst
    dect_core_if #(.W(W)) link ();

    assign link.arm          = arm[g];
    assign link.has_trig     = (cfg_q[g].trig_sel != src_off);
    assign link.count_evt    = qualify(cfg_q[g].cnt_sel, cfg_q[g].cnt_qual,
                                       src_vec, src_prev, src_pulse_type); // [RL4]
    assign link.trig_evt     = qualify(cfg_q[g].trig_sel, cfg_q[g].trig_qual,
                                       src_vec, src_prev, src_pulse_type); // [RL9]
    assign link.clear_evt    = qualify(cfg_q[g].clr_sel, cfg_q[g].clr_qual,
                                       src_vec, src_prev, src_pulse_type); // [RL11]
    assign link.start_delay  = delay_q[g];
    assign link.end_duration = dur_q[g];
    assign cnt_rd[g]         = link.count;
    assign cap_rd[g]         = link.captured;
    assign st_rd[g]          = dect_state_e'(link.state);
    assign begin_evt[g]      = link.begin_evt;
    assign finish_evt[g]     = link.finish_evt;
    assign cnt_evt_dbg[g]    = link.count_evt;

    dect_core #(.W(W)) u_core (
      .clk_i   (core_clk_i),
      .rst_n_i (rst_n),
      .bus     (link)
    );

    a_off_silent: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      cfg_q[g].cnt_sel == src_off |-> !cnt_evt_dbg[g]) // [RL17]
      else $error("off source produced a count event");
    a_src_exclusive: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      !(cfg_q[g].trig_sel != src_off && cfg_q[g].clr_sel != src_off)) // [RL7]
      else $error("trigger and clear both active");
  end

  assign inst_begin_evt_o  = begin_evt;
  assign inst_finish_evt_o = finish_evt;

  // Registered readback of the selected counter
  dect_cfg_s    next_cfg_rb;
  logic [W-1:0] next_delay_rb;
  logic [W-1:0] next_dur_rb;
  logic [W-1:0] next_live;
  logic [W-1:0] next_capt;
  dect_state_e  next_state_rb;

  always_comb
  begin
    next_cfg_rb   = cfg_q[instance_select_i];
    next_delay_rb = delay_q[instance_select_i];
    next_dur_rb   = dur_q[instance_select_i];
    next_live     = cnt_rd[instance_select_i];                 // [RL12]
    next_capt     = cap_rd[instance_select_i];                 // [RL13]
    next_state_rb = st_rd[instance_select_i];                  // [RL14]
  end

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_readback_o   <= CFG_RESET;
      start_delay_o    <= '0;
      end_duration_o   <= '0;
      live_count_o     <= '0;
      captured_count_o <= '0;
      instance_state_o <= state_idle;
    end
    else
    begin
      cfg_readback_o   <= next_cfg_rb;
      start_delay_o    <= next_delay_rb;
      end_duration_o   <= next_dur_rb;
      live_count_o     <= next_live;
      captured_count_o <= next_capt;
      instance_state_o <= next_state_rb;
    end
  end

  a_tick_period: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    $rose(tick) |=> !tick [*8]) // [RL18]
    else $error("microsecond pulse too long or too frequent");
  a_tick_count: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    tick |-> $past(tick_cnt) == TICK_LAST && tick_cnt == '0) // [RL18]
    else $error("microsecond pulse off its period");
  a_live_read: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    $stable(instance_select_i) |=> live_count_o == $past(cnt_rd[instance_select_i])) // [RL12]
    else $error("live count readback wrong");

  c_tick:  cover property (@(posedge core_clk_i) disable iff (!rst_n) tick);
  c_both:  cover property (@(posedge core_clk_i) disable iff (!rst_n) begin_evt == 2'h3);
endmodule

// [verif/test_dual_event_counter_timer.sv]
// Self-checking testbench for the dual event counter timer
`timescale 1ns/10ps
module test_dual_event_counter_timer;
  import dect_pkg::*;

  localparam int W = 8;

  typedef struct {
    dect_src_e  src;
    dect_qual_e q;
    logic       idle;
    logic [7:0] pat;
    int         cnt;
  } dect_row_s;

  logic        clk;
  logic        rstn;
  logic [3:0]  io_a;
  logic [3:0]  sw_out;
  logic [1:0]  lut;
  logic        exp_b;
  logic        exp_f;
  logic        frame_wait;
  logic        inst_sel;
  logic        cfg_wr;
  dect_src_e   cnt_sel;
  dect_qual_e  cnt_q;
  dect_src_e   trg_sel;
  dect_qual_e  trg_q;
  dect_src_e   clr_sel;
  dect_qual_e  clr_q;
  logic [W-1:0] dly;
  logic [W-1:0] dur;
  dect_cfg_s   cfg_rb;
  logic [W-1:0] dly_rb;
  logic [W-1:0] dur_rb;
  logic [W-1:0] live;
  logic [W-1:0] capt;
  dect_state_e state;
  logic        us_pulse;
  logic [1:0]  beg_evt;
  logic [1:0]  fin_evt;
  int          bad_count;
  int          checks_done;
  int          cycles;

  // Patterns are applied least significant bit first
  dect_row_s rows [8] = '{
    '{src_io_a0,               qual_high,       1'b0, 8'h36, 4},
    '{src_sw_output1,          qual_low,        1'b1, 8'hc9, 4},
    '{src_lut_cell0_out,       qual_rise,       1'b0, 8'h36, 2},
    '{src_awaiting_frame_trig, qual_fall,       1'b0, 8'h36, 2},
    '{src_io_a3,               qual_both_edges, 1'b0, 8'h55, 8},
    '{src_sw_output3,          qual_rise,       1'b0, 8'hff, 1},
    '{src_exp_finish,          qual_low,        1'b0, 8'h05, 2},
    '{src_off,                 qual_high,       1'b0, 8'hff, 0}
  };

  dect_top #(
    .W(W)
  ) dut_u (
    .core_clk_i            (clk),
    .rstn_i                (rstn),
    .io_a_i                (io_a),
    .sw_output_i           (sw_out),
    .lut_cell_out_i        (lut),
    .exp_begin_i           (exp_b),
    .exp_finish_i          (exp_f),
    .awaiting_frame_trig_i (frame_wait),
    .instance_select_i     (inst_sel),
    .cfg_write_i           (cfg_wr),
    .count_source_sel_i    (cnt_sel),
    .count_source_qual_i   (cnt_q),
    .start_trig_sel_i      (trg_sel),
    .start_trig_qual_i     (trg_q),
    .clear_src_sel_i       (clr_sel),
    .clear_src_qual_i      (clr_q),
    .start_delay_counts_i  (dly),
    .end_duration_counts_i (dur),
    .cfg_readback_o        (cfg_rb),
    .start_delay_o         (dly_rb),
    .end_duration_o        (dur_rb),
    .live_count_o          (live),
    .captured_count_o      (capt),
    .instance_state_o      (state),
    .microsecond_pulse_o   (us_pulse),
    .inst_begin_evt_o      (beg_evt),
    .inst_finish_evt_o     (fin_evt)
  );

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task tally_and_finish;
    if (bad_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Called at a falling edge; the write is taken at the next rising edge
  task automatic write_cfg(input logic i, input dect_src_e cs, input dect_qual_e cq,
                           input dect_src_e ts, input dect_qual_e tq,
                           input dect_src_e ks, input dect_qual_e kq,
                           input logic [W-1:0] d, input logic [W-1:0] u);
    inst_sel = i;
    cnt_sel  = cs;
    cnt_q    = cq;
    trg_sel  = ts;
    trg_q    = tq;
    clr_sel  = ks;
    clr_q    = kq;
    dly      = d;
    dur      = u;
    cfg_wr   = 1'b1;
    @(negedge clk);
    cfg_wr   = 1'b0;
    repeat (5) @(negedge clk);
  endtask

  task automatic drive_src(input dect_src_e s, input logic v);
    case (s)
      src_io_a3:               io_a[3] = v;
      src_sw_output1:          sw_out[1] = v;
      src_sw_output3:          sw_out[3] = v;
      src_lut_cell0_out:       lut[0] = v;
      src_awaiting_frame_trig: frame_wait = v;
      src_exp_finish:          exp_f = v;
      default:                 io_a[0] = v;
    endcase
  endtask

  task automatic check_reset;
    check(32'(state), 32'(state_idle));
    check(32'(live), 32'h0);
    check(32'(cfg_rb), 32'(CFG_RESET));
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      tally_and_finish;
    end
  end

  initial
  begin
    int n;
    int pb;
    int pf;
    int np;
    {io_a, sw_out, lut, exp_b, exp_f, frame_wait, inst_sel, cfg_wr} = '0;
    cnt_sel = src_off;
    trg_sel = src_off;
    clr_sel = src_off;
    cnt_q   = qual_rise;
    trg_q   = qual_rise;
    clr_q   = qual_rise;
    dly = '0;
    dur = '0;
    rstn = 1'b0;
    bad_count = 0;
    checks_done = 0;
    cycles = 0;
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    check_reset();
    // Count source and qualification table, alternating counters
    for (int i = 0; i < 8; i++)
    begin
      drive_src(rows[i].src, rows[i].idle);
      @(negedge clk);
      write_cfg(i[0], rows[i].src, rows[i].q, src_off, qual_rise, src_off, qual_rise,
                8'h00, 8'hff);
      check(32'(state), 32'(state_running));
      for (int b = 0; b < 8; b++)
      begin
        drive_src(rows[i].src, rows[i].pat[b]);
        @(negedge clk);
      end
      drive_src(rows[i].src, rows[i].idle);
      repeat (4) @(negedge clk);
      check(32'(live), 32'(rows[i].cnt));
      check(32'(cfg_rb.cnt_sel), 32'(rows[i].src));
      check(32'(cfg_rb.cnt_qual), 32'(rows[i].q));
    end
    // Microsecond timer with delay 2 and duration 3 on counter 0
    n = 0;
    while (us_pulse !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    check(32'(us_pulse), 32'h0);
    n = 1;
    while (us_pulse !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    check(32'(n), 32'(TICK_CYCLES));
    inst_sel = 1'b0;
    cnt_sel  = src_microsecond_pulse;
    dly      = 8'h02;
    dur      = 8'h03;
    cfg_wr   = 1'b1;
    @(negedge clk);
    cfg_wr = 1'b0;
    pb = -1;
    pf = -1;
    np = 0;
    for (int k = 0; k < 400 && pf < 0; k++)
    begin
      @(negedge clk);
      if (us_pulse === 1'b1)
        np++;
      if (beg_evt[0] === 1'b1)
        pb = np;
      if (fin_evt[0] === 1'b1)
        pf = np;
    end
    check(32'(pb), 32'h2);
    check(32'(pf), 32'h3);
    repeat (3) @(negedge clk);
    check(32'(state), 32'(state_done));
    check(32'(live), 32'h3);
    // Trigger wins over clear; trigger starts counter 1
    write_cfg(1'b1, src_io_a0, qual_high, src_io_a1, qual_rise, src_io_a2, qual_rise,
              8'h00, 8'h10);
    check(32'(cfg_rb.clr_sel), 32'(src_off));
    check(32'(cfg_rb.trig_sel), 32'(src_io_a1));
    check(32'(state), 32'(state_wait_trig));
    io_a[1] = 1'b1;
    repeat (4) @(negedge clk);
    check(32'(state), 32'(state_running));
    io_a[1] = 1'b0;
    inst_sel = 1'b0;
    repeat (2) @(negedge clk);
    check(32'(state), 32'(state_done));
    // Clear by exposure start pulse captures the count
    write_cfg(1'b1, src_io_a0, qual_high, src_off, qual_rise, src_exp_begin, qual_rise,
              8'h00, 8'h64);
    io_a[0] = 1'b1;
    repeat (5) @(negedge clk);
    io_a[0] = 1'b0;
    repeat (3) @(negedge clk);
    check(32'(live), 32'h5);
    check(32'(dly_rb), 32'h0);
    check(32'(dur_rb), 32'h64);
    exp_b = 1'b1;
    @(negedge clk);
    exp_b = 1'b0;
    repeat (4) @(negedge clk);
    check(32'(capt), 32'h5);
    check(32'(live), 32'h0);
    check(32'(state), 32'(state_running));
    // Overflow past all ones on counter 0
    write_cfg(1'b0, src_io_a0, qual_high, src_off, qual_rise, src_off, qual_rise,
              8'h00, 8'h00);
    io_a[0] = 1'b1;
    repeat (300) @(negedge clk);
    io_a[0] = 1'b0;
    repeat (3) @(negedge clk);
    check(32'(state), 32'(state_wrapped));
    // Second reset in mid-run
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    check_reset();
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    check(32'(state), 32'(state_idle));
    check(32'(live), 32'h0);
    tally_and_finish;
  end
endmodule
